// [rtl/rss_strap_sampler.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - latch each strap level but ldo during system reset
// - latched bits hold until the next system reset
// - five latched bits readable as status
// - weak default pulls applied during reset
// - pins return to normal duty after reset
// - ldo strap pin ignored; strapped voltage always 1.8V
// - boot select: spi, or download when both zero
// - log strap gates console boot output
// - two straps set sdio sample edges
// - firmware may override voltage and sdio edges
// - ldo strap held high on module
// - low enable pin means disabled
module rss_strap_sampler
import rss_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       module_enable_pin,
    input  wire logic                       ldo_voltage_strap,
    input  wire logic                       boot_select_strap,
    input  wire logic                       boot_qualifier_strap,
    input  wire logic                       log_timing_strap,
    input  wire logic                       sdio_edge_strap,
    input  wire logic                       boot_done,
    input  wire logic                       log_data,
    input  wire logic                       volt_ovr_en,
    input  wire logic                       volt_ovr_val,
    input  wire logic                       sdio_ovr_en,
    input  wire rss_pkg::rss_sdio_t         sdio_ovr_val,
    output logic [rss_pkg::STRAP_W-1:0]     strap_capture_status,
    output rss_pkg::rss_cfg_t               cfg_out,
    output rss_pkg::rss_pad_t               pad_ctrl,
    output logic                            console_tx_line,
    output logic                            module_enabled
);
    import rss_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [STRAP_W-1:0] raw_pins;
    logic [STRAP_W-1:0] sync_pins;
    logic [1:0]         en_sync;
    logic               en_meta_ff;
    logic               en_s2_ff;
    logic               en_s3_ff;
    logic               en_ff;

    assign raw_pins = {sdio_edge_strap, log_timing_strap, boot_qualifier_strap,
                       boot_select_strap, ldo_voltage_strap};

    rss_sync3 #(.W(STRAP_W)) u_sync
    (
        .clk     (clk),
        .reset_n (1'b1),
        .d_in    (raw_pins),
        .q_out   (sync_pins)
    );

    // enable pin filtered the same way; runs through reset too
    always_ff @(posedge clk)
    begin
        en_meta_ff <= module_enable_pin;
        en_s2_ff   <= en_meta_ff;
        en_s3_ff   <= en_s2_ff;
    end
    assign en_sync = {en_s3_ff, en_s2_ff};

    always_ff @(posedge clk)
    begin
        if (en_sync[0] == en_sync[1])
            en_ff <= en_sync[1];
    end

    // ------------------------------------------------------------
    // strap latch: transparent in reset, frozen after release
    // ------------------------------------------------------------
    logic [STRAP_W-1:0] strap_ff;
    logic [STRAP_W-1:0] nxt_strap;
    logic               in_reset;

    // module held off by a low enable counts as system reset too
    assign in_reset  = !reset_n || !en_ff;
    // ldo strap forced high: attached memories only run at 1.8V
    assign nxt_strap = {sync_pins[STRAP_W-1:1], 1'b1};

    // the last sample taken with reset still low is the kept one
    always_ff @(posedge clk)
    begin
        if (in_reset)
            strap_ff <= nxt_strap;
    end
    // no write path exists after release, so nothing can disturb it

    // ------------------------------------------------------------
    // derived settings
    // ------------------------------------------------------------
    logic      strap_volt;
    rss_boot_t strap_boot;
    rss_sdio_t strap_sdio;
    logic      boot_window_ff;
    rss_cfg_t  nxt_cfg;

    assign strap_volt = strap_ff[POS_LDO] ? VOLT_1V8 : VOLT_3V3;
    assign strap_boot = strap_ff[POS_BOOT_SEL]  ? RSS_BOOT_SPI :
                        !strap_ff[POS_BOOT_QUAL] ? RSS_BOOT_DOWNLOAD :
                        RSS_BOOT_UNDEF;
    assign strap_sdio = '{in_rising: strap_ff[POS_LOG],
                          out_rising: strap_ff[POS_SDIO]};

    // overrides count only once boot firmware has finished
    assign nxt_cfg.volt_1v8   = (volt_ovr_en && !boot_window_ff) ? volt_ovr_val
                                                                  : strap_volt;
    assign nxt_cfg.sdio_edge  = (sdio_ovr_en && !boot_window_ff) ? sdio_ovr_val
                                                                  : strap_sdio;
    assign nxt_cfg.boot_src   = strap_boot;
    assign nxt_cfg.log_enable = strap_ff[POS_LOG];

    // boot window opens at reset and closes on boot_done
    always_ff @(posedge clk)
    begin
        if (in_reset)
            boot_window_ff <= 1'b1;
        else if (boot_done)
            boot_window_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    rss_cfg_t           cfg_ff;
    rss_pad_t           pad_ff;
    logic [STRAP_W-1:0] status_ff;
    logic               tx_ff;
    logic               nxt_tx;

    // silent log keeps the line idle high; after boot the line is free
    assign nxt_tx = (boot_window_ff && !strap_ff[POS_LOG]) ? 1'b1 : log_data;

    always_ff @(posedge clk)
    begin
        if (in_reset)
        begin
            pad_ff <= '{pull_en: PULL_EN_ALL, pull_up: PULL_UP_MASK,
                        strap_duty: 1'b1};
            tx_ff  <= 1'b1;
        end
        else
        begin
            pad_ff <= '{pull_en: 5'h00, pull_up: 5'h00, strap_duty: 1'b0};
            tx_ff  <= nxt_tx;
        end
    end

    always_ff @(posedge clk)
    begin
        status_ff <= strap_ff;
        cfg_ff    <= nxt_cfg;
    end

    assign strap_capture_status = status_ff;
    assign cfg_out              = cfg_ff;
    assign pad_ctrl             = pad_ff;
    assign console_tx_line      = tx_ff;
    assign module_enabled       = en_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_strap_hold: assert property (@(posedge clk)
        disable iff (!reset_n) !$past(in_reset) && !in_reset |-> $stable(strap_ff))
        else $error("strap latch changed after reset");
    a_ldo_forced: assert property (@(posedge clk)
        !in_reset |-> strap_ff[POS_LDO])
        else $error("ldo strap not held high");
    a_status_follow: assert property (@(posedge clk)
        disable iff (!reset_n) ##1 !$past(in_reset) |-> status_ff == $past(strap_ff))
        else $error("status does not show latched straps");
    a_pull_reset: assert property (@(posedge clk)
        in_reset |=> pad_ff.pull_en == PULL_EN_ALL && pad_ff.pull_up == PULL_UP_MASK)
        else $error("pulls not applied in reset");
    a_pins_released: assert property (@(posedge clk)
        !in_reset |=> !pad_ff.strap_duty && pad_ff.pull_en == 5'h00)
        else $error("pins not released after reset");
    a_boot_spi: assert property (@(posedge clk)
        !in_reset && strap_ff[POS_BOOT_SEL] |=> cfg_ff.boot_src == RSS_BOOT_SPI)
        else $error("spi boot not chosen");
    a_boot_dl: assert property (@(posedge clk)
        !in_reset && strap_ff[2:1] == 2'b00 |=> cfg_ff.boot_src == RSS_BOOT_DOWNLOAD)
        else $error("download boot not chosen");
    a_log_silent: assert property (@(posedge clk)
        disable iff (in_reset) boot_window_ff && !strap_ff[POS_LOG] |=> tx_ff)
        else $error("console toggled while silent");
    a_sdio_edge: assert property (@(posedge clk)
        !sdio_ovr_en && !in_reset
        |=> cfg_ff.sdio_edge == $past({strap_ff[POS_LOG], strap_ff[POS_SDIO]}))
        else $error("sdio edges wrong");
    a_volt_ovr: assert property (@(posedge clk)
        volt_ovr_en && !boot_window_ff |=> cfg_ff.volt_1v8 == $past(volt_ovr_val))
        else $error("voltage override ignored");
    a_enable_low: assert property (@(posedge clk)
        en_sync == 2'b00 |=> !en_ff)
        else $error("low enable not seen as disabled");

    c_spi_boot: cover property (@(posedge clk) $rose(reset_n) ##1 cfg_ff.boot_src == RSS_BOOT_SPI);
    c_dl_boot:  cover property (@(posedge clk) $rose(reset_n) ##1 cfg_ff.boot_src == RSS_BOOT_DOWNLOAD);
    c_override: cover property (@(posedge clk) volt_ovr_en && !boot_window_ff);

    // ------------------------------------------------------------
    // checks on the derived settings and the console line
    // ------------------------------------------------------------
    // regulator select follows the strap whenever no override is in force
    a_volt_strap: assert property (@(posedge clk)
        !in_reset && (!volt_ovr_en || boot_window_ff)
        |=> cfg_ff.volt_1v8 == $past(strap_ff[POS_LDO]))
        else $error("regulator select does not follow strap");

    // firmware edge override takes hold one cycle after the window closes
    a_sdio_ovr: assert property (@(posedge clk)
        sdio_ovr_en && !boot_window_ff
        |=> cfg_ff.sdio_edge == $past(sdio_ovr_val))
        else $error("sdio override ignored");

    // an override raised too early must not leak into the boot settings
    a_ovr_refused: assert property (@(posedge clk)
        boot_window_ff
        |=> cfg_ff.sdio_edge == $past(strap_sdio))
        else $error("sdio override taken during boot");

    // log gate reported as latched, so firmware sees what boot used
    a_log_enable: assert property (@(posedge clk)
        !in_reset
        |=> cfg_ff.log_enable == $past(strap_ff[POS_LOG]))
        else $error("log enable does not follow strap");

    // console line idles high while the device is held in reset
    a_tx_reset: assert property (@(posedge clk)
        in_reset |=> tx_ff)
        else $error("console not idle in reset");

    // qualifier high with select low is no documented mode; flag it
    a_boot_undef: assert property (@(posedge clk)
        !in_reset && strap_ff[2:1] == 2'b10
        |=> cfg_ff.boot_src == RSS_BOOT_UNDEF)
        else $error("undefined boot code not reported");

    // the remaining scenarios worth seeing at least once
    c_sdio_ovr:   cover property (@(posedge clk) sdio_ovr_en && !boot_window_ff);
    c_log_silent: cover property (@(posedge clk)
        !in_reset && boot_window_ff && !strap_ff[POS_LOG]);
endmodule

// [pkg/rss_pkg.sv]
package rss_pkg;

    // ------------------------------------------------------------
    // strap bit positions inside the captured word
    // ------------------------------------------------------------
    localparam int STRAP_W       = 5;
    localparam int POS_LDO       = 0;
    localparam int POS_BOOT_SEL  = 1;
    localparam int POS_BOOT_QUAL = 2;
    localparam int POS_LOG       = 3;
    localparam int POS_SDIO      = 4;

    // ------------------------------------------------------------
    // pull directions applied while reset is active (1 = pull-up)
    // ------------------------------------------------------------
    localparam logic [4:0] PULL_UP_MASK = 5'h1a;
    localparam logic [4:0] PULL_EN_ALL  = 5'h1f;
    localparam logic [4:0] STRAP_RESET  = 5'h1b;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic VOLT_3V3 = 1'b0;
    localparam logic VOLT_1V8 = 1'b1;

    typedef enum logic [1:0] {
        RSS_BOOT_DOWNLOAD,
        RSS_BOOT_SPI,
        RSS_BOOT_UNDEF
    } rss_boot_t;

    typedef struct packed {
        logic in_rising;
        logic out_rising;
    } rss_sdio_t;

    typedef struct packed {
        logic       volt_1v8;
        rss_boot_t  boot_src;
        logic       log_enable;
        rss_sdio_t  sdio_edge;
    } rss_cfg_t;

    typedef struct packed {
        logic [4:0] pull_en;
        logic [4:0] pull_up;
        logic       strap_duty;
    } rss_pad_t;

endpackage

// [rtl/rss_sync3.sv]
`timescale 1ns/1ps
module rss_sync3
#(
    parameter int W = 5
)
(
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    // ------------------------------------------------------------
    // three stages; outside reset the output moves only when stages two and three agree
    // ------------------------------------------------------------
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] agree;

    assign agree = ~(s2_ff ^ s3_ff);

    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        s1_ff <= d_in;
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            q_ff <= '0;
        else
            q_ff <= (agree & s3_ff) | (~agree & q_ff);
    end

    assign q_out = q_ff;
endmodule

// [bench/rss_strap_host.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// far side: host drivers and the device's weak pulls (from pad_ctrl) on the five straps
// ------------------------------------------------------------
module rss_strap_host
(
    input  wire logic              clk,
    input  wire rss_pkg::rss_pad_t pad_ctrl,
    input  wire logic [4:0]        drv_en,
    input  wire logic [4:0]        drv_val,
    output logic [4:0]             pins
);
    import rss_pkg::*;

    logic [4:0] flt_ff = 5'h15;

    // a pin nobody holds wanders, so a stale level never passes for a capture
    always_ff @(posedge clk)
    begin
        flt_ff <= ~flt_ff;
    end

    // host drive beats the weak pull; the pull only counts while enabled
    // only the five straps are modelled, flash pins are never touched
    assign pins = (drv_en & drv_val)
                | (~drv_en & pad_ctrl.pull_en & pad_ctrl.pull_up)
                | (~drv_en & ~pad_ctrl.pull_en & flt_ff);
endmodule

// [bench/rss_strap_sampler_tb.sv]
`timescale 1ns/1ps
module rss_strap_sampler_tb;
    import rss_pkg::*;

    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        en_pin = 1'b1;
    logic        boot_done = 1'b0;
    logic        log_data = 1'b0;
    logic        vo_en = 1'b0;
    logic        vo_val = 1'b0;
    logic        so_en = 1'b0;
    rss_sdio_t   so_val = 2'h0;
    logic [4:0]  drv_en = 5'h00;
    logic [4:0]  drv_val = 5'h00;
    logic [4:0]  pins;
    logic [4:0]  status;
    rss_cfg_t    cfg;
    rss_pad_t    pad;
    logic        tx;
    logic        enabled;
    logic        chk = 1'b0;
    logic [47:0] notes [$];
    logic [47:0] n;
    int          failures = 0;
    int          tests_run = 0;
    int          seed = 40;
    logic [4:0]  tbl [8] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h10, 5'h18, 5'h1f};
    wire  [23:0] seen = {status, cfg, tx, pad, enabled};

    always #10 clk = ~clk;

    // ------------------------------------------------------------
    // device and far side
    // ------------------------------------------------------------
    rss_strap_sampler dut (.clk(clk), .reset_n(reset_n), .module_enable_pin(en_pin),
        .ldo_voltage_strap(pins[0]), .boot_select_strap(pins[1]),
        .boot_qualifier_strap(pins[2]), .log_timing_strap(pins[3]),
        .sdio_edge_strap(pins[4]), .boot_done(boot_done), .log_data(log_data),
        .volt_ovr_en(vo_en), .volt_ovr_val(vo_val), .sdio_ovr_en(so_en),
        .sdio_ovr_val(so_val), .strap_capture_status(status), .cfg_out(cfg),
        .pad_ctrl(pad), .console_tx_line(tx), .module_enabled(enabled));

    rss_strap_host host (.clk(clk), .pad_ctrl(pad), .drv_en(drv_en), .drv_val(drv_val),
        .pins(pins));

    // ------------------------------------------------------------
    // expectations and checking
    // ------------------------------------------------------------
    // expected word for captured straps s; post means the boot window has closed
    function automatic logic [23:0] want(input logic [4:0] s, input logic post);
        logic [5:0] c;
        c[5] = (post && vo_en) ? vo_val : s[POS_LDO];
        c[4:3] = s[POS_BOOT_SEL] ? RSS_BOOT_SPI : (s[POS_BOOT_QUAL] ? RSS_BOOT_UNDEF
                                                                   : RSS_BOOT_DOWNLOAD);
        c[2] = s[POS_LOG];
        c[1:0] = (post && so_en) ? so_val : {s[POS_LOG], s[POS_SDIO]};
        want = {s, c, ~s[POS_LOG], 11'h000, 1'b1};
    endfunction

    task automatic note(input logic [23:0] v, input logic [23:0] m);
        notes.push_back({v, m});
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
    endtask

    // watcher: oldest note against what the outputs show, masked fields only
    always @(posedge clk)
    begin
        if (chk && notes.size() > 0)
        begin
            n = notes.pop_front();
            tests_run++;
            if (((seen ^ n[47:24]) & n[23:0]) !== 24'h000000)
            begin
                failures++;
                $display("Error at %0t: got %h expected %h", $time, seen & n[23:0], n[47:24]);
            end
        end
    end

    // one reset, capture and boot window, with pins scrambled after release
    task automatic trial(input logic [4:0] s, input logic [4:0] de);
        logic [4:0] eff;
        eff = (de & s) | (~de & PULL_UP_MASK);
        eff[POS_LDO] = 1'b1;
        reset_n <= 1'b0;
        boot_done <= 1'b0;
        drv_en <= de;
        drv_val <= s;
        vo_en <= 1'($random(seed));
        vo_val <= 1'($random(seed));
        so_en <= 1'($random(seed));
        so_val <= 2'($random(seed));
        repeat (8) @(posedge clk);
        note({11'h000, 1'b1, PULL_EN_ALL, PULL_UP_MASK, 1'b1, 1'b0}, 24'h001ffe);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        drv_en <= 5'h1f;
        drv_val <= 5'($random(seed));
        repeat (4) @(posedge clk);
        note(want(eff, 1'b0), 24'hffffff);
        boot_done <= 1'b1;
        repeat (3) @(posedge clk);
        note(want(eff, 1'b1), 24'hffefff);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence: defaults, every boot and sdio code, then random
    // ------------------------------------------------------------
    initial
    begin
        for (int i = 0; i < 12; i++)
            trial(i < 8 ? tbl[i] : 5'($random(seed)),
                  i == 0 ? 5'h00 : (i < 8 ? 5'h1f : 5'($random(seed))));
        en_pin <= 1'b0;
        repeat (8) @(posedge clk);
        note(24'h000000, 24'h000001);
        en_pin <= 1'b1;
        repeat (8) @(posedge clk);
        note(24'h000001, 24'h000001);
        repeat (2) @(posedge clk);
        print_verdict();
    end

    // watchdog well beyond the few hundred cycles the sequence needs
    initial
    begin
        #(20 * 4000);
        failures++;
        print_verdict();
    end
endmodule
